// ===== include/spl_pkg.sv
// Constants and types for the serial port link status block
// Notes on behaviour
// - Speed strap sampled at power up; code 100 is illegal and keeps down every link whose rate is not overridden.
// - Eight-bit configuration strap sampled at power up sets each port's initial width.
// - Undefined width code in strap bits 1:0 or 3:2 blocks link-up, reports 4x.
// - Two- or four-lane port comes up only when every lane trained; else withheld.
// - One status register per lane 0..47 at 0x002010 plus 0x20 per lane.
// - Reading a lane status register returns its contents, then clears its changed flag and error count.
// - Lane status holds a trained flag and a sticky trained-changed flag.
// - Lane status counts decode errors received on that lane, saturating at 255.
// - Disabled port passes no packets and no control symbols.
// - Link-up follows control character exchange; it does not by itself allow packets.
// - Halted port neither issues nor accepts any packets.
// - Data packets go out only with output enable, come in only with input enable.
// - Input and output error flags clear on write of one; they never stop traffic.
// - Fatal port error discards every packet, maintenance responses included.
// - Error causes kept per port in a standard and an extra cause register.
// - Per-lane transmit drive strength setting, maximum 63.
// - Per-lane transmit post-emphasis setting, 0 to 63.
// - Per-lane transmit pre-emphasis setting, 0 to 31.
// - Per-lane receive feedback equaliser enable and adjustment.
// - Software may override each port's link rate.
// - Width override value 010 forces a port to a single active lane.
package spl_pkg;
    localparam int SPL_NLANE = 48;
    localparam int SPL_NPORT = 12;
    localparam logic [5:0] SPL_NLANE_C = 6'h30;
    localparam logic [5:0] SPL_NPORT_C = 6'h0c;
    // Register map, byte addresses
    localparam logic [23:0] SPL_LANE_STAT_BASE = 24'h002010;
    localparam logic [23:0] SPL_LANE_CFG_BASE = 24'h002014;
    localparam logic [23:0] SPL_PORT_CTL_BASE = 24'h001000;
    localparam logic [23:0] SPL_PORT_ERR_BASE = 24'h001004;
    localparam logic [23:0] SPL_PORT_CAUSE_BASE = 24'h001008;
    localparam logic [23:0] SPL_PORT_XCAUSE_BASE = 24'h00100c;
    // Port control fields
    localparam int SPL_CTL_OUT_EN = 0;
    localparam int SPL_CTL_IN_EN = 1;
    localparam int SPL_CTL_DIS = 8;
    localparam int SPL_CTL_HALT = 9;
    localparam int SPL_CTL_WOVR_LSB = 12;
    localparam int SPL_CTL_SOVR_EN = 15;
    localparam int SPL_CTL_SOVR_LSB = 16;
    localparam logic [31:0] SPL_CTL_RST = 32'h00000003;
    localparam logic [31:0] SPL_CTL_MASK = 32'h0007f303;
    // Port error state fields
    localparam int SPL_ERR_LINK_UP = 0;
    localparam int SPL_ERR_IN = 1;
    localparam int SPL_ERR_OUT = 2;
    localparam int SPL_ERR_FATAL = 3;
    // Lane status fields
    localparam int SPL_LST_TRAINED = 0;
    localparam int SPL_LST_CHG = 1;
    localparam int SPL_LST_CNT_LSB = 8;
    // Lane configuration fields and reset value
    localparam int SPL_LCF_DRIVE_LSB = 0;
    localparam int SPL_LCF_POST_LSB = 8;
    localparam int SPL_LCF_PRE_LSB = 16;
    localparam int SPL_LCF_DFE_EN = 24;
    localparam int SPL_LCF_DFE_LSB = 25;
    localparam logic [31:0] SPL_LCF_RST = 32'h00000020;
    localparam logic [31:0] SPL_LCF_MASK = 32'h7f1f3f3f;
    // Codes
    localparam logic [2:0] SPL_SPD_ILLEGAL = 3'h4;
    localparam logic [2:0] SPL_WOVR_1X = 3'h2;
    localparam logic [1:0] SPL_STRAP_4X = 2'h0;
    localparam logic [1:0] SPL_STRAP_2X = 2'h1;
    localparam logic [1:0] SPL_STRAP_1X = 2'h2;
    localparam logic [7:0] SPL_CNT_MAX = 8'hff;
    typedef enum logic [1:0] {SPL_W1X, SPL_W2X, SPL_W4X} spl_width_t;
endpackage

// ===== src/spl_link_status.sv
// Per-port and per-lane link control and status of a multi-port serial switch
`timescale 1ns/10ps
module spl_link_status (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Power-up straps
    input wire logic [2:0] speed_strap,
    input wire logic [7:0] cfg_strap,
    // Register port
    input wire logic [23:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rack,
    // Lane receivers
    input wire logic [spl_pkg::SPL_NLANE-1:0] lane_rx_trained,
    input wire logic [spl_pkg::SPL_NLANE-1:0] lane_decode_err,
    // Port events
    input wire logic [spl_pkg::SPL_NPORT-1:0] port_ctrl_seen,
    input wire logic [spl_pkg::SPL_NPORT-1:0][7:0] port_cause_evt,
    input wire logic [spl_pkg::SPL_NPORT-1:0][7:0] port_xcause_evt,
    input wire logic [spl_pkg::SPL_NPORT-1:0] port_fatal_evt,
    // Port status and traffic gating
    output logic [spl_pkg::SPL_NPORT-1:0] port_link_up,
    output spl_pkg::spl_width_t [spl_pkg::SPL_NPORT-1:0] port_width,
    output logic [spl_pkg::SPL_NPORT-1:0][2:0] port_speed,
    output logic [spl_pkg::SPL_NPORT-1:0] port_ctrl_ok,
    output logic [spl_pkg::SPL_NPORT-1:0] port_maint_ok,
    output logic [spl_pkg::SPL_NPORT-1:0] port_tx_data_ok,
    output logic [spl_pkg::SPL_NPORT-1:0] port_rx_data_ok,
    // Lane transmit and receive settings
    output logic [spl_pkg::SPL_NLANE-1:0][5:0] lane_drive,
    output logic [spl_pkg::SPL_NLANE-1:0][5:0] lane_post,
    output logic [spl_pkg::SPL_NLANE-1:0][4:0] lane_pre,
    output logic [spl_pkg::SPL_NLANE-1:0] lane_dfe_en,
    output logic [spl_pkg::SPL_NLANE-1:0][5:0] lane_dfe_tap
);
    import spl_pkg::*;

    // Hit flag and word index of an address inside a strided array
    function automatic logic [6:0] dec(input logic [23:0] a, input logic [23:0] base,
                                       input logic [5:0] n);
        logic [23:0] d;
        d = a - base;
        dec = {(a >= base) && (d[4:0] == 5'h00) && (d[23:5] < {13'h0000, n}), d[10:5]};
    endfunction

    function automatic logic [3:0] lane_mask(input spl_width_t w);
        case (w)
            SPL_W1X: lane_mask = 4'h1;
            SPL_W2X: lane_mask = 4'h3;
            default: lane_mask = 4'hf;
        endcase
    endfunction

    logic straps_taken_r;
    logic [2:0] spd_strap_r;
    logic [7:0] cfg_strap_r;
    logic [SPL_NPORT-1:0][31:0] ctl_r;
    logic [SPL_NPORT-1:0] in_err_r, out_err_r, fatal_r;
    logic [SPL_NPORT-1:0][7:0] cause_r, xcause_r;
    logic [SPL_NLANE-1:0][31:0] lcf_r;
    logic [SPL_NLANE-1:0] tr_r, chg_r;
    logic [SPL_NLANE-1:0][7:0] cnt_r;
    logic [SPL_NLANE-1:0] tr_eff, chg_evt;
    logic [SPL_NPORT-1:0] speed_bad, width_bad, up_nxt, maint_nxt;
    logic [SPL_NPORT-1:0][2:0] eff_speed;
    spl_width_t [SPL_NPORT-1:0] eff_width;
    logic [6:0] d_lst, d_lcf, d_ctl, d_err, d_cau, d_xca;
    logic stat_rd;
    logic [31:0] rd_mux;

    assign d_lst = dec(reg_addr, SPL_LANE_STAT_BASE, SPL_NLANE_C);
    assign d_lcf = dec(reg_addr, SPL_LANE_CFG_BASE, SPL_NLANE_C);
    assign d_ctl = dec(reg_addr, SPL_PORT_CTL_BASE, SPL_NPORT_C);
    assign d_err = dec(reg_addr, SPL_PORT_ERR_BASE, SPL_NPORT_C);
    assign d_cau = dec(reg_addr, SPL_PORT_CAUSE_BASE, SPL_NPORT_C);
    assign d_xca = dec(reg_addr, SPL_PORT_XCAUSE_BASE, SPL_NPORT_C);
    assign stat_rd = reg_rd && d_lst[6];

    // Straps caught once, on the first edge after reset release
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            straps_taken_r <= 1'b0;
            spd_strap_r <= 3'h0;
            cfg_strap_r <= 8'h00;
        end else if (!straps_taken_r) begin
            straps_taken_r <= 1'b1;
            spd_strap_r <= speed_strap;
            cfg_strap_r <= cfg_strap;
        end
    end

    // Effective rate, width and link-up per port
    always_comb begin
        logic [1:0] code;
        logic upper;
        code = 2'h0;
        upper = 1'b0;
        for (int p = 0; p < SPL_NPORT; p++) begin
            code = cfg_strap_r[2*(p/3) +: 2];
            upper = (p / 3) >= 2;
            eff_speed[p] = ctl_r[p][SPL_CTL_SOVR_EN] ?
                           ctl_r[p][SPL_CTL_SOVR_LSB +: 3] : spd_strap_r;
            speed_bad[p] = eff_speed[p] == SPL_SPD_ILLEGAL;
            width_bad[p] = (code == 2'h3) && !upper;
            case (code)
                SPL_STRAP_2X: eff_width[p] = SPL_W2X;
                SPL_STRAP_1X: eff_width[p] = SPL_W1X;
                SPL_STRAP_4X: eff_width[p] = SPL_W4X;
                default: eff_width[p] = upper ? SPL_W1X : SPL_W4X;
            endcase
            if (ctl_r[p][SPL_CTL_WOVR_LSB +: 3] == SPL_WOVR_1X) begin
                eff_width[p] = SPL_W1X;
            end
            // All lanes of the width must train; partial training keeps the port down
            up_nxt[p] = straps_taken_r && !speed_bad[p] && !width_bad[p]
                        && !ctl_r[p][SPL_CTL_DIS] && port_ctrl_seen[p]
                        && ((tr_eff[4*p +: 4] & lane_mask(eff_width[p]))
                            == lane_mask(eff_width[p]));
            maint_nxt[p] = up_nxt[p] && !ctl_r[p][SPL_CTL_HALT] && !fatal_r[p];
        end
    end

    // Illegal rate means a lane never counts as trained
    always_comb begin
        for (int l = 0; l < SPL_NLANE; l++) begin
            tr_eff[l] = lane_rx_trained[l] && straps_taken_r && !speed_bad[l/4]
                        && !ctl_r[l/4][SPL_CTL_DIS];
            chg_evt[l] = tr_eff[l] != tr_r[l];
        end
    end

    // Lane status, cleared by a read; a same-cycle event survives the clear
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tr_r <= '0;
            chg_r <= '0;
            cnt_r <= '0;
        end else begin
            for (int l = 0; l < SPL_NLANE; l++) begin
                tr_r[l] <= tr_eff[l];
                if (stat_rd && d_lst[5:0] == 6'(l)) begin
                    chg_r[l] <= chg_evt[l];
                    cnt_r[l] <= {7'h00, lane_decode_err[l]};
                end else begin
                    chg_r[l] <= chg_r[l] | chg_evt[l];
                    if (lane_decode_err[l] && cnt_r[l] != SPL_CNT_MAX) begin
                        cnt_r[l] <= cnt_r[l] + 8'h01;
                    end
                end
            end
        end
    end

    // Lane analog settings
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lcf_r <= {SPL_NLANE{SPL_LCF_RST}};
        end else if (reg_wr && d_lcf[6]) begin
            lcf_r[d_lcf[5:0]] <= reg_wdata & SPL_LCF_MASK;
        end
    end

    always_comb begin
        for (int l = 0; l < SPL_NLANE; l++) begin
            lane_drive[l] = lcf_r[l][SPL_LCF_DRIVE_LSB +: 6];
            lane_post[l] = lcf_r[l][SPL_LCF_POST_LSB +: 6];
            lane_pre[l] = lcf_r[l][SPL_LCF_PRE_LSB +: 5];
            lane_dfe_en[l] = lcf_r[l][SPL_LCF_DFE_EN];
            lane_dfe_tap[l] = lcf_r[l][SPL_LCF_DFE_LSB +: 6];
        end
    end

    // Port control
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_r <= {SPL_NPORT{SPL_CTL_RST}};
        end else if (reg_wr && d_ctl[6]) begin
            ctl_r[d_ctl[3:0]] <= reg_wdata & SPL_CTL_MASK;
        end
    end

    // Error flags and causes; low cause bits are input side, high bits output side
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            in_err_r <= '0;
            out_err_r <= '0;
            fatal_r <= '0;
            cause_r <= '0;
            xcause_r <= '0;
        end else begin
            for (int p = 0; p < SPL_NPORT; p++) begin
                logic wr_e, wr_c, wr_x;
                wr_e = reg_wr && d_err[6] && d_err[3:0] == 4'(p);
                wr_c = reg_wr && d_cau[6] && d_cau[3:0] == 4'(p);
                wr_x = reg_wr && d_xca[6] && d_xca[3:0] == 4'(p);
                in_err_r[p] <= (|port_cause_evt[p][3:0]) || (|port_xcause_evt[p][3:0])
                               || (in_err_r[p] && !(wr_e && reg_wdata[SPL_ERR_IN]));
                out_err_r[p] <= (|port_cause_evt[p][7:4]) || (|port_xcause_evt[p][7:4])
                                || (out_err_r[p] && !(wr_e && reg_wdata[SPL_ERR_OUT]));
                fatal_r[p] <= port_fatal_evt[p]
                              || (fatal_r[p] && !(wr_e && reg_wdata[SPL_ERR_FATAL]));
                cause_r[p] <= port_cause_evt[p]
                              | (cause_r[p] & ~(wr_c ? reg_wdata[7:0] : 8'h00));
                xcause_r[p] <= port_xcause_evt[p]
                               | (xcause_r[p] & ~(wr_x ? reg_wdata[7:0] : 8'h00));
            end
        end
    end

    // Gating; input and output error flags deliberately stay out of it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            port_link_up <= '0;
            port_width <= '{default: SPL_W1X};
            port_speed <= '0;
            port_ctrl_ok <= '0;
            port_maint_ok <= '0;
            port_tx_data_ok <= '0;
            port_rx_data_ok <= '0;
        end else begin
            for (int p = 0; p < SPL_NPORT; p++) begin
                port_link_up[p] <= up_nxt[p];
                port_width[p] <= eff_width[p];
                port_speed[p] <= eff_speed[p];
                port_ctrl_ok[p] <= !ctl_r[p][SPL_CTL_DIS];
                port_maint_ok[p] <= maint_nxt[p];
                port_tx_data_ok[p] <= maint_nxt[p] && ctl_r[p][SPL_CTL_OUT_EN];
                port_rx_data_ok[p] <= maint_nxt[p] && ctl_r[p][SPL_CTL_IN_EN];
            end
        end
    end

    // Read mux; unmapped addresses read zero
    always_comb begin
        rd_mux = 32'h00000000;
        if (d_lst[6]) begin
            rd_mux = {16'h0000, cnt_r[d_lst[5:0]], 6'h00, chg_r[d_lst[5:0]],
                      tr_r[d_lst[5:0]]};
        end else if (d_lcf[6]) begin
            rd_mux = lcf_r[d_lcf[5:0]];
        end else if (d_ctl[6]) begin
            rd_mux = ctl_r[d_ctl[3:0]];
        end else if (d_err[6]) begin
            rd_mux = {28'h0000000, fatal_r[d_err[3:0]], out_err_r[d_err[3:0]],
                      in_err_r[d_err[3:0]], port_link_up[d_err[3:0]]};
        end else if (d_cau[6]) begin
            rd_mux = {24'h000000, cause_r[d_cau[3:0]]};
        end else if (d_xca[6]) begin
            rd_mux = {24'h000000, xcause_r[d_xca[3:0]]};
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 32'h00000000;
            reg_rack <= 1'b0;
        end else begin
            reg_rack <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rd_mux;
            end
        end
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_speed_illegal;
        (speed_bad != 12'h000) |=> ((port_link_up & $past(speed_bad)) == 12'h000);
    endproperty
    a_speed_illegal: assert property (p_speed_illegal) else $error("link up at illegal rate");

    property p_strap_hold;
        straps_taken_r |=> $stable(cfg_strap_r) && $stable(spd_strap_r);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after capture");

    property p_width_bad;
        (width_bad[3] && ctl_r[3][SPL_CTL_WOVR_LSB +: 3] != SPL_WOVR_1X)
            |=> !port_link_up[3] && port_width[3] == SPL_W4X;
    endproperty
    a_width_bad: assert property (p_width_bad) else $error("bad width strap misreported");

    property p_all_lanes;
        (port_link_up[0] && port_width[0] == SPL_W4X) |-> $past(tr_eff[3:0]) == 4'hf;
    endproperty
    a_all_lanes: assert property (p_all_lanes) else $error("4x up with untrained lane");

    property p_read_clear;
        (stat_rd && d_lst[5:0] == 6'h00 && !lane_decode_err[0] && !chg_evt[0])
            |=> !chg_r[0] && cnt_r[0] == 8'h00;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("lane status not cleared");

    property p_chg_kept;
        chg_evt[0] |=> chg_r[0] [*1] ##0 tr_r[0] == $past(tr_eff[0]);
    endproperty
    a_chg_kept: assert property (p_chg_kept) else $error("trained change lost");

    property p_err_cnt;
        (lane_decode_err[0] && !(stat_rd && d_lst[5:0] == 6'h00) && cnt_r[0] != SPL_CNT_MAX)
            |=> cnt_r[0] == $past(cnt_r[0]) + 8'h01;
    endproperty
    a_err_cnt: assert property (p_err_cnt) else $error("decode error not counted");

    property p_disable;
        ctl_r[0][SPL_CTL_DIS] |=> !port_ctrl_ok[0] && !port_maint_ok[0]
            && !port_tx_data_ok[0] && !port_rx_data_ok[0];
    endproperty
    a_disable: assert property (p_disable) else $error("disabled port passes traffic");

    property p_link_up;
        port_link_up[0] |-> $past(port_ctrl_seen[0]);
    endproperty
    a_link_up: assert property (p_link_up) else $error("link up without control exchange");

    property p_halt;
        ctl_r[0][SPL_CTL_HALT] |=> !port_maint_ok[0] && !port_tx_data_ok[0]
            && !port_rx_data_ok[0];
    endproperty
    a_halt: assert property (p_halt) else $error("halted port passes packets");

    property p_enables;
        !ctl_r[0][SPL_CTL_OUT_EN] |=> !port_tx_data_ok[0];
    endproperty
    a_enables: assert property (p_enables) else $error("tx data without output enable");

    property p_w1c;
        (reg_wr && d_err[6] && d_err[3:0] == 4'h0 && reg_wdata[SPL_ERR_IN]
         && port_cause_evt[0][3:0] == 4'h0 && port_xcause_evt[0][3:0] == 4'h0)
            |=> !in_err_r[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("input error not cleared");

    property p_fatal;
        fatal_r[0] |=> !port_maint_ok[0] && !port_tx_data_ok[0] && !port_rx_data_ok[0];
    endproperty
    a_fatal: assert property (p_fatal) else $error("fatal port passes packets");

    property p_cause;
        port_cause_evt[0][0] |=> cause_r[0][0] && in_err_r[0];
    endproperty
    a_cause: assert property (p_cause) else $error("cause not recorded");

    property p_wovr;
        ctl_r[0][SPL_CTL_WOVR_LSB +: 3] == SPL_WOVR_1X |=> port_width[0] == SPL_W1X;
    endproperty
    a_wovr: assert property (p_wovr) else $error("width override ignored");

    property p_sovr;
        ctl_r[0][SPL_CTL_SOVR_EN] |=> port_speed[0] == $past(ctl_r[0][SPL_CTL_SOVR_LSB +: 3]);
    endproperty
    a_sovr: assert property (p_sovr) else $error("rate override ignored");

    property p_cv_up;
        !port_link_up[0] ##1 port_link_up[0] && port_tx_data_ok[0];
    endproperty
    c_up: cover property (p_cv_up);
    property p_cv_clear_evt;
        stat_rd && d_lst[5:0] == 6'h00 && lane_decode_err[0] ##1 cnt_r[0] == 8'h01;
    endproperty
    c_clear_evt: cover property (p_cv_clear_evt);

    property p_cv_fatal;
        port_link_up[0] && fatal_r[0] ##1 !port_maint_ok[0];
    endproperty
    c_fatal: cover property (p_cv_fatal);
endmodule

// ===== tb/spl_link_partner.sv
// Behavioural link partner driving lane training, decode errors and control exchange
`timescale 1ns/10ps
module spl_link_partner (
    // Clock
    input wire logic mclk,
    // Requests from the bench
    input wire logic slow,
    input wire logic [47:0] lanes_on,
    input wire logic [47:0] err_on,
    input wire logic [11:0] ctrl_on,
    // Toward the device
    output logic [47:0] lane_rx_trained,
    output logic [47:0] lane_decode_err,
    output logic [11:0] port_ctrl_seen
);
    logic [47:0] tr_d = '0;
    initial begin
        lane_rx_trained = '0;
        lane_decode_err = '0;
        port_ctrl_seen = '0;
    end
    // Slow mode trains a cycle later, as a sluggish far end would
    always @(negedge mclk) begin
        tr_d <= lanes_on;
        lane_rx_trained <= slow ? tr_d : lanes_on;
        lane_decode_err <= err_on;
        port_ctrl_seen <= ctrl_on;
    end
endmodule

// ===== tb/spl_link_status_test.sv
// Self-checking bench for the serial port link status block
`timescale 1ns/10ps
module spl_link_status_test;
    import spl_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [2:0] speed_strap = 3'h1;
    logic [7:0] cfg_strap = 8'h6c;
    logic [23:0] reg_addr = 24'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] rd_d;
    logic reg_rack;
    logic slow = 1'b0;
    logic [47:0] lanes_on = '0;
    logic [47:0] err_on = '0;
    logic [11:0] ctrl_on = '0;
    logic [47:0] lane_rx_trained;
    logic [47:0] lane_decode_err;
    logic [11:0] port_ctrl_seen;
    logic [11:0] port_fatal_evt = '0;
    logic [11:0][7:0] port_cause_evt = '0;
    logic [11:0][7:0] port_xcause_evt = '0;
    logic [11:0] port_link_up;
    logic [11:0] port_ctrl_ok;
    logic [11:0] port_maint_ok;
    logic [11:0] port_tx_data_ok;
    logic [11:0] port_rx_data_ok;
    spl_width_t [11:0] port_width;
    logic [11:0][2:0] port_speed;
    logic [47:0][5:0] lane_drive;
    logic [47:0][5:0] lane_post;
    logic [47:0][5:0] lane_dfe_tap;
    logic [47:0][4:0] lane_pre;
    logic [47:0] lane_dfe_en;
    logic [3:0] ok0;
    logic [31:0] ctl_v [5] = '{32'h1, 32'h2, 32'h0, 32'h203, 32'h103};
    logic [3:0] ok_v [5] = '{4'he, 4'hd, 4'hc, 4'h8, 4'h0};
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    assign ok0 = {port_ctrl_ok[0], port_maint_ok[0], port_tx_data_ok[0], port_rx_data_ok[0]};
    always #12.5 mclk = ~mclk;
    spl_link_status uut (.mclk(mclk), .sys_rst(sys_rst), .speed_strap(speed_strap),
        .cfg_strap(cfg_strap), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rack(reg_rack),
        .lane_rx_trained(lane_rx_trained), .lane_decode_err(lane_decode_err),
        .port_ctrl_seen(port_ctrl_seen), .port_cause_evt(port_cause_evt),
        .port_xcause_evt(port_xcause_evt), .port_fatal_evt(port_fatal_evt),
        .port_link_up(port_link_up), .port_width(port_width), .port_speed(port_speed),
        .port_ctrl_ok(port_ctrl_ok), .port_maint_ok(port_maint_ok),
        .port_tx_data_ok(port_tx_data_ok), .port_rx_data_ok(port_rx_data_ok),
        .lane_drive(lane_drive), .lane_post(lane_post), .lane_pre(lane_pre),
        .lane_dfe_en(lane_dfe_en), .lane_dfe_tap(lane_dfe_tap));
    spl_link_partner partner (.mclk(mclk), .slow(slow), .lanes_on(lanes_on), .err_on(err_on),
        .ctrl_on(ctrl_on), .lane_rx_trained(lane_rx_trained),
        .lane_decode_err(lane_decode_err), .port_ctrl_seen(port_ctrl_seen));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Entered just after a falling edge; answer lands one cycle after the request
    task automatic rd(input logic [23:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(negedge mclk);
        chk(32'(reg_rack), 32'h1);
        d = reg_rdata;
        reg_rd <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(negedge mclk);
        reg_wr <= 1'b0;
        @(negedge mclk);
    endtask
    // Hang guard, well above the roughly 110 cycles the sequence needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            error_cnt++;
            $display("MISMATCH t=%0t timeout", $time);
            final_report();
        end
    end
    initial begin
        tick(4);
        sys_rst <= 1'b0;
        tick(2);
        rd(SPL_PORT_CTL_BASE, rd_d);
        chk(rd_d, SPL_CTL_RST);
        rd(SPL_LANE_CFG_BASE, rd_d);
        chk(rd_d, SPL_LCF_RST);
        chk(32'(port_speed[0]), 32'h1);
        chk(32'(port_width[0]), 32'(SPL_W4X));
        chk(32'(port_width[3]), 32'(SPL_W4X));
        chk(32'(port_width[6]), 32'(SPL_W1X));
        chk(32'(port_width[9]), 32'(SPL_W2X));
        $display("test straps done");
        // Ports 0 and 9 one lane short, port 3 on an undefined strap
        lanes_on <= 48'h0010_0100_f007;
        ctrl_on <= 12'h249;
        tick(4);
        chk(32'(port_link_up), 32'h040);
        slow <= 1'b1;
        lanes_on <= 48'h0030_0100_f00f;
        tick(5);
        chk(32'(port_link_up), 32'h241);
        $display("test training done");
        rd(SPL_LANE_STAT_BASE, rd_d);
        chk(rd_d, 32'h3);
        rd(SPL_LANE_STAT_BASE, rd_d);
        chk(rd_d, 32'h1);
        rd(SPL_LANE_STAT_BASE + 24'h20, rd_d);
        err_on <= 48'h2;
        tick(3);
        err_on <= '0;
        tick(2);
        rd(SPL_LANE_STAT_BASE + 24'h20, rd_d);
        chk(rd_d, 32'h0301);
        err_on <= 48'h2;
        tick(1);
        err_on <= '0;
        rd(SPL_LANE_STAT_BASE + 24'h20, rd_d);
        rd(SPL_LANE_STAT_BASE + 24'h20, rd_d);
        chk(rd_d, 32'h0101);
        err_on <= 48'h8000_0000_0000;
        tick(1);
        err_on <= '0;
        tick(2);
        rd(SPL_LANE_STAT_BASE + 24'h5e0, rd_d);
        chk(rd_d, 32'h0100);
        $display("test lane status done");
        chk(32'(ok0), 32'hf);
        for (int i = 0; i < 5; i++) begin
            wr(SPL_PORT_CTL_BASE, ctl_v[i]);
            tick(2);
            chk(32'(ok0), 32'(ok_v[i]));
        end
        wr(SPL_PORT_CTL_BASE, SPL_CTL_RST);
        tick(6);
        chk(32'(ok0), 32'hf);
        $display("test gating done");
        port_cause_evt[0] <= 8'h01;
        port_xcause_evt[0] <= 8'h10;
        tick(1);
        port_cause_evt[0] <= 8'h00;
        port_xcause_evt[0] <= 8'h00;
        tick(2);
        rd(SPL_PORT_ERR_BASE, rd_d);
        chk(rd_d, 32'h7);
        chk(32'(ok0), 32'hf);
        rd(SPL_PORT_CAUSE_BASE, rd_d);
        chk(rd_d, 32'h01);
        rd(SPL_PORT_XCAUSE_BASE, rd_d);
        chk(rd_d, 32'h10);
        wr(SPL_PORT_ERR_BASE, 32'h6);
        rd(SPL_PORT_ERR_BASE, rd_d);
        chk(rd_d, 32'h1);
        port_fatal_evt[0] <= 1'b1;
        tick(1);
        port_fatal_evt[0] <= 1'b0;
        tick(2);
        chk(32'(ok0), 32'h8);
        rd(SPL_PORT_ERR_BASE, rd_d);
        chk(rd_d, 32'h9);
        wr(SPL_PORT_ERR_BASE, 32'h8);
        tick(1);
        chk(32'(ok0), 32'hf);
        $display("test errors done");
        wr(SPL_LANE_CFG_BASE, SPL_LCF_MASK);
        chk(32'({lane_drive[0], lane_post[0], lane_pre[0], lane_dfe_en[0], lane_dfe_tap[0]}),
            32'hffffff);
        rd(SPL_LANE_CFG_BASE, rd_d);
        chk(rd_d, SPL_LCF_MASK);
        wr(SPL_PORT_CTL_BASE, 32'h0002a003);
        tick(1);
        chk(32'(port_width[0]), 32'(SPL_W1X));
        chk(32'(port_speed[0]), 32'h2);
        rd(24'h000ff0, rd_d);
        chk(rd_d, 32'h0);
        $display("test settings done");
        // Illegal rate strap keeps every link down even with lanes trained
        sys_rst <= 1'b1;
        speed_strap <= SPL_SPD_ILLEGAL;
        tick(4);
        sys_rst <= 1'b0;
        tick(8);
        chk(32'(port_link_up), 32'h0);
        $display("test illegal strap done");
        final_report();
    end
endmodule
